/* rtccs_top.sv */
// rtccs_top: rtc clock source select, oscillator control and card supply regulator control
`timescale 1ns/1ps
module rtccs_top
  import rtccs_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic                   pready,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pslverr,
  // clock sources, sampled levels
  input  wire logic              slowOscIn,
  input  wire logic              slowCrystalIn,
  input  wire logic              mainCrystalIn,
  input  wire logic              mainPllIn,
  input  wire logic              audioPllIn,
  input  wire logic              fastOscIn,
  // power manager status
  input  wire logic              oscAutoPowerReq,
  input  wire logic              sleepActive,
  input  wire logic              supplyReadyIn,
  // rtc domain clocks
  output logic                   slowClockOut,
  output logic                   fastClockOut,
  output logic                   systemClockOut,
  // digital core clocks
  output logic                   coreOscClk,
  output logic                   coreDividedOscClk,
  output logic                   coreSlowCrystalClk,
  // oscillator control
  output logic                   oscPowerUp,
  output logic [7:0]             oscFreqTrim,
  // card supply regulator control
  output logic                   regEnable,
  output logic [1:0]             regHighTrim,
  output logic [1:0]             regMidTrim,
  output logic [1:0]             regLowTrim,
  output logic                   regTieHigh
);

  ////////////////////////////////////////////////////////////////////////////////
  // register fields

  logic [1:0]       slowSel;
  logic             fastSel;
  logic [1:0]       sysSel;
  logic             forcePowerUp;
  logic             forcePowerDown;
  logic [7:0]       freqTrim;
  logic [2:0]       divSel;
  logic             coreOscGate;
  logic             coreDivGate;
  logic             coreXtalGate;
  logic             dividerBypass;
  logic             oscDisable;
  logic [1:0]       outputRatio;

  logic             swRegEnable;
  logic [1:0]       swHighTrim;
  logic [1:0]       swMidTrim;
  logic [1:0]       swLowTrim;
  logic             swTieHigh;
  logic             regOverride;
  logic             sleepPdEnable;
  logic             supplyReady;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic             apbAccess;
  logic             apbWrite;
  logic             hitClock;
  logic             hitRegulator;
  logic [DATA_W-1:0] next_prdata;

  function automatic logic [DIV_W-1:0] ratio_divisor(input logic [1:0] code);
    ratio_divisor = BASE_RATIO << code;
  endfunction

  // one wait state: pready rises on the second access cycle
  assign apbAccess    = psel && penable && !pready;
  assign apbWrite     = psel && penable && pready && pwrite && !pslverr;
  assign hitClock     = (paddr == ADDR_CLOCK_CONF);
  assign hitRegulator = (paddr == ADDR_REGULATOR);

  always_comb begin
    next_prdata = '0;
    if (hitClock) begin
      next_prdata[SLOW_SEL_LSB +: 2]  = slowSel;
      next_prdata[FAST_SEL_BIT]       = fastSel;
      next_prdata[SYS_SEL_LSB +: 2]   = sysSel;
      next_prdata[FORCE_PU_BIT]       = forcePowerUp;
      next_prdata[FORCE_PD_BIT]       = forcePowerDown;
      next_prdata[FREQ_TRIM_LSB +: 8] = freqTrim;
      next_prdata[DIV_SEL_LSB +: 3]   = divSel;
      next_prdata[CORE_OSC_BIT]       = coreOscGate;
      next_prdata[CORE_DIV_BIT]       = coreDivGate;
      next_prdata[CORE_XTAL_BIT]      = coreXtalGate;
      next_prdata[BYPASS_BIT]         = dividerBypass;
      next_prdata[DISABLE_BIT]        = oscDisable;
      next_prdata[RATIO_LSB +: 2]     = outputRatio;
    end else if (hitRegulator) begin
      next_prdata[REG_EN_BIT]         = swRegEnable;
      next_prdata[HIGH_TRIM_LSB +: 2] = swHighTrim;
      next_prdata[MID_TRIM_LSB +: 2]  = swMidTrim;
      next_prdata[LOW_TRIM_LSB +: 2]  = swLowTrim;
      next_prdata[READY_BIT]          = supplyReady;
      next_prdata[TIE_HIGH_BIT]       = swTieHigh;
      next_prdata[OVERRIDE_BIT]       = regOverride;
      next_prdata[SLEEP_PD_BIT]       = sleepPdEnable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess && !hitClock && !hitRegulator;
      if (apbAccess && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slowSel        <= SLOW_INTERNAL;
      fastSel        <= 1'b0;
      sysSel         <= SYS_CRYSTAL;
      forcePowerUp   <= 1'b0;
      forcePowerDown <= 1'b0;
      freqTrim       <= RST_FREQ_TRIM;
      divSel         <= RST_DIV_SEL;
      coreOscGate    <= 1'b0;
      coreDivGate    <= RST_CORE_DIV;
      coreXtalGate   <= 1'b0;
      dividerBypass  <= 1'b0;
      oscDisable     <= 1'b0;
      outputRatio    <= RST_RATIO;
    end else if (apbWrite && hitClock) begin
      slowSel        <= pwdata[SLOW_SEL_LSB +: 2];
      fastSel        <= pwdata[FAST_SEL_BIT];
      sysSel         <= pwdata[SYS_SEL_LSB +: 2];
      forcePowerUp   <= pwdata[FORCE_PU_BIT];
      forcePowerDown <= pwdata[FORCE_PD_BIT];
      freqTrim       <= pwdata[FREQ_TRIM_LSB +: 8];
      divSel         <= pwdata[DIV_SEL_LSB +: 3];
      coreOscGate    <= pwdata[CORE_OSC_BIT];
      coreDivGate    <= pwdata[CORE_DIV_BIT];
      coreXtalGate   <= pwdata[CORE_XTAL_BIT];
      dividerBypass  <= pwdata[BYPASS_BIT];
      oscDisable     <= pwdata[DISABLE_BIT];
      outputRatio    <= pwdata[RATIO_LSB +: 2];
    end
  end

  // ready bit is not written here, so writes to it are lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swRegEnable   <= 1'b0;
      swHighTrim    <= RST_HIGH_TRIM;
      swMidTrim     <= RST_MID_TRIM;
      swLowTrim     <= RST_LOW_TRIM;
      swTieHigh     <= RST_TIE_HIGH;
      regOverride   <= 1'b0;
      sleepPdEnable <= RST_SLEEP_PD;
    end else if (apbWrite && hitRegulator) begin
      swRegEnable   <= pwdata[REG_EN_BIT];
      swHighTrim    <= pwdata[HIGH_TRIM_LSB +: 2];
      swMidTrim     <= pwdata[MID_TRIM_LSB +: 2];
      swLowTrim     <= pwdata[LOW_TRIM_LSB +: 2];
      swTieHigh     <= pwdata[TIE_HIGH_BIT];
      regOverride   <= pwdata[OVERRIDE_BIT];
      sleepPdEnable <= pwdata[SLEEP_PD_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supplyReady <= 1'b0;
    end else begin
      supplyReady <= supplyReadyIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator power and run control

  logic next_oscPowerUp;
  logic oscLive;

  always_comb begin
    if (forcePowerDown) begin
      next_oscPowerUp = 1'b0;
    end else if (forcePowerUp) begin
      next_oscPowerUp = 1'b1;
    end else begin
      next_oscPowerUp = oscAutoPowerReq;
    end
  end

  // an unpowered oscillator is treated as stopped too
  assign oscLive = next_oscPowerUp && !oscDisable;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oscPowerUp  <= 1'b0;
      oscFreqTrim <= RST_FREQ_TRIM;
    end else begin
      oscPowerUp  <= next_oscPowerUp;
      oscFreqTrim <= freqTrim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // source edge detection and dividers

  logic fastOscPrev;
  logic mainCrystalPrev;
  logic fastOscRise;
  logic mainCrystalRise;
  logic oscDivLevel;
  logic oscDivRise;
  logic quarterLevel;
  logic d256Level;
  logic [DIV_W-1:0] oscDivisor;
  logic [DIV_W-1:0] d256Divisor;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fastOscPrev     <= 1'b0;
      mainCrystalPrev <= 1'b0;
    end else begin
      fastOscPrev     <= fastOscIn;
      mainCrystalPrev <= mainCrystalIn;
    end
  end

  assign fastOscRise     = fastOscIn && !fastOscPrev;
  assign mainCrystalRise = mainCrystalIn && !mainCrystalPrev;
  assign oscDivisor      = {{(DIV_W-3){1'b0}}, divSel} + DIV_ONE;
  // bypass turns the second stage into a straight pass
  assign d256Divisor     = dividerBypass ? DIV_ONE : ratio_divisor(outputRatio);

  rtccs_clk_div u_osc_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (oscLive),
    .srcLevel (fastOscIn),
    .srcRise  (fastOscRise),
    .divisor  (oscDivisor),
    .divLevel (oscDivLevel),
    .divRise  (oscDivRise)
  );

  rtccs_clk_div u_d256_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (oscLive),
    .srcLevel (oscDivLevel),
    .srcRise  (oscDivRise),
    .divisor  (d256Divisor),
    .divLevel (d256Level),
    .divRise  ()
  );

  rtccs_clk_div u_quarter_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (1'b1),
    .srcLevel (mainCrystalIn),
    .srcRise  (mainCrystalRise),
    .divisor  (XTAL_QUARTER),
    .divLevel (quarterLevel),
    .divRise  ()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock selection and core gating

  logic next_slowClock;
  logic next_systemClock;

  always_comb begin
    unique case (slowSel)
      SLOW_CRYSTAL: next_slowClock = slowCrystalIn;
      SLOW_DIVIDED: next_slowClock = d256Level;
      default:      next_slowClock = slowOscIn;
    endcase
  end

  always_comb begin
    unique case (sysSel)
      SYS_CRYSTAL:   next_systemClock = mainCrystalIn;
      SYS_MAIN_PLL:  next_systemClock = mainPllIn;
      SYS_FAST_OSC:  next_systemClock = oscDivLevel;
      SYS_AUDIO_PLL: next_systemClock = audioPllIn;
    endcase
  end

  // sampled-mux model: outputs lag sources by one clk, glitch-free switching is not attempted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slowClockOut   <= 1'b0;
      fastClockOut   <= 1'b0;
      systemClockOut <= 1'b0;
    end else begin
      slowClockOut   <= next_slowClock;
      fastClockOut   <= fastSel ? oscDivLevel : quarterLevel;
      systemClockOut <= next_systemClock;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreOscClk         <= 1'b0;
      coreDividedOscClk  <= 1'b0;
      coreSlowCrystalClk <= 1'b0;
    end else begin
      coreOscClk         <= coreOscGate && oscDivLevel;
      coreDividedOscClk  <= coreDivGate && d256Level;
      coreSlowCrystalClk <= coreXtalGate && slowCrystalIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // card supply regulator

  rtccs_reg_state_t regState;
  rtccs_reg_state_t next_regState;

  always_comb begin
    next_regState = regState;
    unique case (regState)
      REG_ON: begin
        if (sleepActive && sleepPdEnable) begin
          next_regState = REG_OFF;
        end
      end
      REG_OFF: begin
        if (!sleepActive || !sleepPdEnable) begin
          next_regState = REG_ON;
        end
      end
    endcase
  end

  // machine keeps tracking sleep while overridden, so handing back is seamless
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regState <= REG_ON;
    end else begin
      regState <= next_regState;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regEnable   <= 1'b0;
      regHighTrim <= AUTO_HIGH_TRIM;
      regMidTrim  <= AUTO_MID_TRIM;
      regLowTrim  <= AUTO_LOW_TRIM;
      regTieHigh  <= AUTO_TIE_HIGH;
    end else if (regOverride) begin
      regEnable   <= swRegEnable;
      regHighTrim <= swHighTrim;
      regMidTrim  <= swMidTrim;
      regLowTrim  <= swLowTrim;
      regTieHigh  <= swTieHigh;
    end else begin
      regEnable   <= (next_regState == REG_ON);
      regHighTrim <= AUTO_HIGH_TRIM;
      regMidTrim  <= AUTO_MID_TRIM;
      regLowTrim  <= AUTO_LOW_TRIM;
      regTieHigh  <= AUTO_TIE_HIGH;
    end
  end

endmodule // rtccs_top

/* rtccs_pkg.sv */
// rtccs_pkg: register map, field layout, reset values and codes of the rtc clock source block
package rtccs_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [9:0]  IDX_CLOCK_CONF    = 10'h01C;
  localparam logic [9:0]  IDX_REGULATOR     = 10'h01D;
  localparam logic [11:0] ADDR_CLOCK_CONF   = {IDX_CLOCK_CONF, 2'b00};
  localparam logic [11:0] ADDR_REGULATOR    = {IDX_REGULATOR, 2'b00};
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;

  // rtc_clock_configuration fields
  localparam int SLOW_SEL_LSB   = 30;
  localparam int FAST_SEL_BIT   = 29;
  localparam int SYS_SEL_LSB    = 27;
  localparam int FORCE_PU_BIT   = 26;
  localparam int FORCE_PD_BIT   = 25;
  localparam int FREQ_TRIM_LSB  = 17;
  localparam int DIV_SEL_LSB    = 12;
  localparam int CORE_OSC_BIT   = 10;
  localparam int CORE_DIV_BIT   = 9;
  localparam int CORE_XTAL_BIT  = 8;
  localparam int BYPASS_BIT     = 7;
  localparam int DISABLE_BIT    = 6;
  localparam int RATIO_LSB      = 4;

  // sdio_regulator_configuration fields
  localparam int REG_EN_BIT     = 31;
  localparam int HIGH_TRIM_LSB  = 29;
  localparam int MID_TRIM_LSB   = 27;
  localparam int LOW_TRIM_LSB   = 25;
  localparam int READY_BIT      = 24;
  localparam int TIE_HIGH_BIT   = 23;
  localparam int OVERRIDE_BIT   = 22;
  localparam int SLEEP_PD_BIT   = 21;

  // reset values
  localparam logic [2:0] RST_DIV_SEL     = 3'h2;
  localparam logic [1:0] RST_RATIO       = 2'h1;
  localparam logic       RST_CORE_DIV    = 1'b1;
  localparam logic [7:0] RST_FREQ_TRIM   = 8'h00;
  localparam logic [1:0] RST_HIGH_TRIM   = 2'h0;
  localparam logic [1:0] RST_MID_TRIM    = 2'h0;
  localparam logic [1:0] RST_LOW_TRIM    = 2'h1;
  localparam logic       RST_TIE_HIGH    = 1'b1;
  localparam logic       RST_SLEEP_PD    = 1'b1;

  // trims driven while the state machine owns the regulator
  localparam logic [1:0] AUTO_HIGH_TRIM  = 2'h0;
  localparam logic [1:0] AUTO_MID_TRIM   = 2'h0;
  localparam logic [1:0] AUTO_LOW_TRIM   = 2'h1;
  localparam logic       AUTO_TIE_HIGH   = 1'b1;

  // source codes
  localparam logic [1:0] SLOW_INTERNAL   = 2'h0;
  localparam logic [1:0] SLOW_CRYSTAL    = 2'h1;
  localparam logic [1:0] SLOW_DIVIDED    = 2'h2;
  localparam logic [1:0] SYS_CRYSTAL     = 2'h0;
  localparam logic [1:0] SYS_MAIN_PLL    = 2'h1;
  localparam logic [1:0] SYS_FAST_OSC    = 2'h2;
  localparam logic [1:0] SYS_AUDIO_PLL   = 2'h3;

  // divider figures
  localparam int         DIV_W           = 11;
  localparam logic [10:0] XTAL_QUARTER   = 11'h004;
  localparam logic [10:0] BASE_RATIO     = 11'h080;
  localparam logic [10:0] DIV_ONE        = 11'h001;

  typedef enum logic {REG_ON, REG_OFF} rtccs_reg_state_t;

endpackage

/* rtccs_clk_div.sv */
// rtccs_clk_div: divides a sampled source clock by a run-time ratio
`timescale 1ns/1ps
module rtccs_clk_div
  import rtccs_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // source
  input  wire logic             enable,
  input  wire logic             srcLevel,
  input  wire logic             srcRise,
  input  wire logic [DIV_W-1:0] divisor,
  // divided clock
  output logic                  divLevel,
  output logic                  divRise
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic             passThrough;

  assign passThrough = (divisor <= DIV_ONE);
  assign next_count  = (count >= divisor - DIV_ONE) ? '0 : count + DIV_ONE;

  // ratio changes apply to the running count at once without restarting it; only a ratio of one or zero clears the count
  always_ff @(posedge clk) begin
    if (!rst_n || !enable || passThrough) begin
      count <= '0;
    end else if (srcRise) begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      divLevel <= 1'b0;
      divRise  <= 1'b0;
    end else if (passThrough) begin
      divLevel <= srcLevel;
      divRise  <= srcRise;
    end else begin
      if (srcRise) begin
        divLevel <= (next_count < (divisor >> 1));
      end
      divRise <= srcRise && (next_count == '0);
    end
  end

endmodule // rtccs_clk_div

/* rtccs_top_asserts.sv */
// rtccs_top_asserts: port checker for rtccs_top, bound below
`timescale 1ns/1ps
module rtccs_top_asserts
  import rtccs_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // status and outputs
  input wire logic              sleepActive,
  input wire logic              oscPowerUp,
  input wire logic              coreOscClk,
  input wire logic              coreDividedOscClk,
  input wire logic              coreSlowCrystalClk,
  input wire logic              regEnable,
  input wire logic [1:0]        regHighTrim,
  input wire logic [1:0]        regLowTrim,
  input wire logic              regTieHigh
);
  logic [DATA_W-1:0] confShadow;
  logic [DATA_W-1:0] regShadow;
  logic              mapped;
  logic              wrDone;
  assign mapped = (paddr == ADDR_CLOCK_CONF) || (paddr == ADDR_REGULATOR);
  assign wrDone = psel && penable && pready && pwrite;
  // mirror of written words, so outputs are judged against what software asked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      confShadow <= 32'h0000_2210;
      regShadow  <= 32'h02A0_0000;
    end else if (wrDone && paddr == ADDR_CLOCK_CONF) begin
      confShadow <= pwdata;
    end else if (wrDone && paddr == ADDR_REGULATOR) begin
      regShadow <= pwdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // outputs lag the register by up to three cycles
  sequence s_conf_settled; $stable(confShadow) [*4]; endsequence
  sequence s_sw_owned; (regShadow[OVERRIDE_BIT] && $stable(regShadow)) [*2]; endsequence
  sequence s_auto_sleep;
    !regShadow[OVERRIDE_BIT] && regShadow[SLEEP_PD_BIT] && sleepActive && $stable(regShadow);
  endsequence
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_slverr_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  chk_force_pu: assert property (
    s_conf_settled ##0 confShadow[FORCE_PU_BIT] && !confShadow[FORCE_PD_BIT] |-> oscPowerUp)
    else $error("forced power up ignored");
  chk_force_pd: assert property (s_conf_settled ##0 confShadow[FORCE_PD_BIT] |-> !oscPowerUp)
    else $error("forced power down ignored");
  chk_gate_osc: assert property (s_conf_settled ##0 !confShadow[CORE_OSC_BIT] |-> !coreOscClk)
    else $error("core osc clock leaks while gated");
  chk_gate_div: assert property (
    s_conf_settled ##0 !confShadow[CORE_DIV_BIT] |-> !coreDividedOscClk)
    else $error("core divided clock leaks while gated");
  chk_gate_xtal: assert property (
    s_conf_settled ##0 !confShadow[CORE_XTAL_BIT] |-> !coreSlowCrystalClk)
    else $error("core crystal clock leaks while gated");
  chk_osc_disable: assert property (
    s_conf_settled ##0 confShadow[DISABLE_BIT] |-> !coreOscClk && !coreDividedOscClk)
    else $error("disabled oscillator still toggles");
  chk_sw_override: assert property (s_sw_owned |->
    regEnable == regShadow[REG_EN_BIT] && regHighTrim == regShadow[HIGH_TRIM_LSB +: 2]
    && regLowTrim == regShadow[LOW_TRIM_LSB +: 2] && regTieHigh == regShadow[TIE_HIGH_BIT])
    else $error("software regulator settings not applied");
  chk_auto_trims: assert property (
    (!regShadow[OVERRIDE_BIT] && $stable(regShadow)) [*2] |-> regHighTrim == AUTO_HIGH_TRIM
    && regLowTrim == AUTO_LOW_TRIM && regTieHigh == AUTO_TIE_HIGH)
    else $error("software trims leak in automatic mode");
  chk_sleep_off: assert property (s_auto_sleep ##1 s_auto_sleep |=> !regEnable)
    else $error("regulator on during sleep");
endmodule // rtccs_top_asserts

bind rtccs_top rtccs_top_asserts u_rtccs_top_asserts (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .sleepActive, .oscPowerUp, .coreOscClk,
  .coreDividedOscClk, .coreSlowCrystalClk, .regEnable, .regHighTrim, .regLowTrim, .regTieHigh);

/* rtccs_top_tb.sv */
// rtccs_top_tb: self-checking bench for rtccs_top over apb
`timescale 1ns/1ps
module rtccs_top_tb;
  import rtccs_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        slowOscIn, slowCrystalIn, mainCrystalIn, mainPllIn, audioPllIn, fastOscIn;
  logic        oscAutoPowerReq, sleepActive, supplyReadyIn, oscRun, xtalRun;
  logic        slowClockOut, fastClockOut, systemClockOut, oscPowerUp;
  logic        coreOscClk, coreDividedOscClk, coreSlowCrystalClk;
  logic        regEnable, regTieHigh;
  logic [1:0]  regHighTrim, regMidTrim, regLowTrim, ph;
  logic [7:0]  oscFreqTrim;
  int          fails, n_tests;
  rtccs_top u_rtccs_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .slowOscIn, .slowCrystalIn, .mainCrystalIn, .mainPllIn, .audioPllIn,
    .fastOscIn, .oscAutoPowerReq, .sleepActive, .supplyReadyIn, .slowClockOut, .fastClockOut,
    .systemClockOut, .coreOscClk, .coreDividedOscClk, .coreSlowCrystalClk, .oscPowerUp,
    .oscFreqTrim, .regEnable, .regHighTrim, .regMidTrim, .regLowTrim, .regTieHigh);
  initial begin clk = 0; forever #2 clk = ~clk; end
  // oscillator rises every 4 cycles, main crystal every 2
  always @(posedge clk) begin
    ph <= ph + 2'd1;
    if (oscRun) fastOscIn <= ph[1];
    if (xtalRun) mainCrystalIn <= ph[0];
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin fails++; $display("ERROR t=%0t apb no answer", $time); end
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1, a, d, r, e);
    repeat (6) @(posedge clk);
  endtask
  function automatic logic [31:0] cw(logic [1:0] sl, logic fs, logic [1:0] sy, logic pu,
      logic pd, logic [2:0] dv, logic co, logic cd, logic cx, logic by, logic ds, logic [1:0] ra);
    return {sl, fs, sy, pu, pd, 10'h000, dv, 1'b0, co, cd, cx, by, ds, ra, 4'h0};
  endfunction
  // cycles between the 2nd and 3rd rise; the first may still use the old ratio
  task automatic measure(input int s, input int lim, output int p);
    int n, r, t; logic c, l;
    n = 0; r = 0; p = 0; t = 0; l = 1;
    while (r < 3 && n < lim) begin
      @(negedge clk);
      n++;
      c = (s == 0) ? coreDividedOscClk : (s == 1) ? fastClockOut : coreOscClk;
      if (c && !l) begin r++; if (r == 3) p = n - t; t = n; end
      l = c;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] r; logic e;
    apb(0, ADDR_CLOCK_CONF, 0, r, e); ck(r, 32'h0000_2210, "conf reset");
    supplyReadyIn <= 1;
    apb(0, ADDR_REGULATOR, 0, r, e); ck(r, 32'h03A0_0000, "reg reset");
    supplyReadyIn <= 0;
    apb(1, ADDR_REGULATOR, 32'h03A0_0000, r, e);
    apb(0, ADDR_REGULATOR, 0, r, e); ck(r, 32'h02A0_0000, "ready bit");
    apb(0, 12'h078, 0, r, e); ck(32'(e), 1, "unmapped read");
    $display("t_regs done");
  endtask
  task automatic t_regulator();
    wr(ADDR_REGULATOR, 32'h7040_0000);
    ck(32'({regEnable, regHighTrim, regMidTrim, regLowTrim, regTieHigh}), 8'h70, "sw");
    wr(ADDR_REGULATOR, 32'h8040_0000);
    ck(32'({regEnable, regHighTrim, regMidTrim, regLowTrim, regTieHigh}), 8'h80, "sw");
    wr(ADDR_REGULATOR, 32'hF020_0000);
    ck(32'({regEnable, regHighTrim, regMidTrim, regLowTrim, regTieHigh}), 8'h83, "auto");
    sleepActive <= 1;
    repeat (4) @(posedge clk);
    ck(32'(regEnable), 0, "sleep");
    wr(ADDR_REGULATOR, 32'h0000_0000);
    ck(32'(regEnable), 1, "no sleep pd");
    sleepActive <= 0;
    $display("t_regulator done");
  endtask
  task automatic t_select();
    int p;
    for (int c = 0; c < 4; c++) for (int s = 0; s < 2; s++) begin
      slowOscIn <= s[0]; slowCrystalIn <= !s[0];
      wr(ADDR_CLOCK_CONF, cw(c[1:0], 0, 0, 0, 0, 2, 0, 1, 0, 0, 0, 1));
      ck(32'(slowClockOut), (c == 1) ? !s[0] : (c == 2) ? 0 : s[0], "slow sel");
    end
    for (int c = 0; c < 4; c++) begin
      mainCrystalIn <= c != 1 && c != 3; mainPllIn <= c == 1 || c == 2; audioPllIn <= c >= 2;
      wr(ADDR_CLOCK_CONF, cw(0, 0, c[1:0], 0, 0, 2, 0, 1, 0, 0, 0, 1));
      ck(32'(systemClockOut), c != 2, "sys sel");
    end
    xtalRun <= 1;
    measure(1, 200, p); ck(p, 8, "crystal quarter");
    xtalRun <= 0;
    $display("t_select done");
  endtask
  task automatic t_divider();
    int p;
    oscRun <= 1;
    wr(ADDR_CLOCK_CONF, cw(0, 1, 0, 1, 0, 1, 1, 1, 0, 0, 0, 0));
    measure(0, 4000, p); ck(p, 1024, "div 128");
    measure(1, 200, p); ck(p, 8, "fast osc");
    measure(2, 200, p); ck(p, 8, "core osc");
    wr(ADDR_CLOCK_CONF, cw(0, 1, 0, 1, 0, 1, 1, 1, 0, 0, 0, 3));
    measure(0, 30000, p); ck(p, 8192, "div 1024");
    wr(ADDR_CLOCK_CONF, cw(0, 1, 0, 1, 0, 1, 1, 1, 0, 1, 0, 0));
    measure(0, 200, p); ck(p, 8, "bypass");
    wr(ADDR_CLOCK_CONF, cw(2, 1, 0, 1, 0, 0, 1, 1, 0, 0, 0, 1));
    measure(0, 4000, p); ck(p, 1024, "div 256");
    wr(ADDR_CLOCK_CONF, cw(2, 1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1));
    measure(0, 3000, p); ck(p, 0, "disabled div");
    measure(2, 200, p); ck(p, 0, "disabled osc");
    wr(ADDR_CLOCK_CONF, cw(0, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0, 1));
    measure(2, 200, p); ck(p, 0, "osc gated");
    measure(0, 3000, p); ck(p, 0, "div gated");
    oscRun <= 0;
    $display("t_divider done");
  endtask
  task automatic t_power();
    slowCrystalIn <= 1;
    // trim field 0xAA rides along to reach the trim output
    wr(ADDR_CLOCK_CONF, cw(0, 0, 0, 1, 0, 2, 0, 1, 1, 0, 0, 1) | 32'h0154_0000);
    ck(32'(oscPowerUp), 1, "force up");
    ck(32'(oscFreqTrim), 32'h0000_00AA, "freq trim");
    ck(32'(coreSlowCrystalClk), 1, "xtal gate on");
    oscAutoPowerReq <= 1;
    wr(ADDR_CLOCK_CONF, cw(0, 0, 0, 1, 1, 2, 0, 1, 0, 0, 0, 1));
    ck(32'(oscPowerUp), 0, "force down");
    ck(32'(coreSlowCrystalClk), 0, "xtal gate off");
    $display("t_power done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400_000;
    fails++;
    $display("ERROR t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ph, oscRun, xtalRun} = '0;
    {slowOscIn, slowCrystalIn, mainCrystalIn, mainPllIn, audioPllIn, fastOscIn} = '0;
    {oscAutoPowerReq, sleepActive, supplyReadyIn} = '0;
    fails = 0; n_tests = 0; rst_n = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    t_regs();
    t_regulator();
    t_select();
    t_divider();
    t_power();
    tally_and_finish();
  end
endmodule // rtccs_top_tb
